//--- hdl/supervisor_pkg.sv
// Constants and types for the fault restart and overtorque supervisor
package supervisor_pkg;
    localparam int CLOCK_HZ = 100_000_000;
    localparam int TICK_MS = 100;
    localparam int TICK_CYCLES = CLOCK_HZ / 1000 * TICK_MS;
    localparam int HEALTHY_MINUTES = 10;
    localparam int HEALTHY_TICKS = HEALTHY_MINUTES * 60 * 1000 / TICK_MS;
    localparam logic [3:0] RESTART_LIMIT_MAX = 4'hA;
    localparam logic [3:0] RESTART_LIMIT_RESET = 4'h0;
    localparam logic RESTART_CONTACT_RESET = 1'b0;
    localparam logic [2:0] MODE_OFF = 3'h0;
    localparam logic [2:0] MODE_AGREE_ALARM = 3'h1;
    localparam logic [2:0] MODE_ANY_ALARM = 3'h2;
    localparam logic [2:0] MODE_AGREE_FAULT = 3'h3;
    localparam logic [2:0] MODE_ANY_FAULT = 3'h4;
    localparam logic [2:0] MODE_RESET = 3'h0;
    localparam logic [8:0] LEVEL_MAX = 9'h12C;
    localparam logic [8:0] LEVEL_RESET = 9'h096;
    localparam logic [8:0] HYSTERESIS = 9'h005;
    localparam logic [6:0] TIME_MAX = 7'h64;
    localparam logic [6:0] TIME_RESET = 7'h01;
    localparam logic [4:0] FUNC_RESTARTING = 5'h1E;
    localparam logic [4:0] FUNC_TORQUE1_NO = 5'h0B;
    localparam logic [4:0] FUNC_TORQUE1_NC = 5'h17;
    localparam logic [4:0] FUNC_TORQUE2_NO = 5'h18;
    localparam logic [4:0] FUNC_TORQUE2_NC = 5'h19;
    localparam int FAULT_BITS = 13;
    localparam int TRIP_A_BIT = 11;
    localparam int TRIP_B_BIT = 12;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_RESTART = 3'b010,
        ST_LATCHED = 3'b100
    } restart_state_t;
endpackage

//--- hdl/torque_channel.sv
// One overtorque detection channel
`timescale 1ns/10ps
`default_nettype none
module torque_channel
#(
    parameter int TIME_WIDTH = 7
)
(
    input wire logic CLOCK,
    input wire logic RESETN,
    input wire logic CE,
    input wire logic TICK,
    input wire logic [2:0] MODE,
    input wire logic [8:0] LEVEL,
    input wire logic [TIME_WIDTH-1:0] QUAL_TIME,
    input wire logic [8:0] SENSED,
    input wire logic SPEED_AGREE,
    output logic DETECTED,
    output logic FAULT_EVENT
);
    import supervisor_pkg::*;
    if (TIME_WIDTH < 7)
    begin : g_width_check
        $error("TIME_WIDTH too small");
    end
    logic [TIME_WIDTH:0] qual_count;
    logic armed;
    // Mode and speed agreement decide whether to look now
    assign armed = (MODE == MODE_ANY_ALARM) || (MODE == MODE_ANY_FAULT) ||
        (((MODE == MODE_AGREE_ALARM) || (MODE == MODE_AGREE_FAULT)) && SPEED_AGREE);
    wire logic above = armed && (SENSED > LEVEL);
    wire logic [9:0] release_level = {1'b0, LEVEL} - {1'b0, HYSTERESIS};
    wire logic released = !armed || release_level[9] || ({1'b0, SENSED} < release_level);
    wire logic qualified = qual_count > {1'b0, QUAL_TIME};
    wire logic stop_mode = (MODE == MODE_AGREE_FAULT) || (MODE == MODE_ANY_FAULT);
    always_ff @(posedge CLOCK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            qual_count <= '0;
            DETECTED <= 1'b0;
            FAULT_EVENT <= 1'b0;
        end
        else if (CE)
        begin
            if (!above)
                qual_count <= '0;
            else if (TICK && !qualified)
                qual_count <= qual_count + 1'b1;
            if (DETECTED && released)
                DETECTED <= 1'b0;
            else if (above && qualified)
                DETECTED <= 1'b1;
            FAULT_EVENT <= above && qualified && !DETECTED && stop_mode;
        end
    end
    property p_short_dropped;
        @(posedge CLOCK) disable iff (!RESETN)
        (CE && !above && !DETECTED) |=> !DETECTED;
    endproperty
    a_short_dropped: assert property (p_short_dropped) else $error("overtorque without qualification");
    property p_hold_hyst;
        @(posedge CLOCK) disable iff (!RESETN)
        (CE && DETECTED && !released) |=> DETECTED;
    endproperty
    a_hold_hyst: assert property (p_hold_hyst) else $error("detection dropped inside hysteresis");
    property p_mode_off;
        @(posedge CLOCK) disable iff (!RESETN)
        (CE && MODE == MODE_OFF) |=> ##1 !DETECTED || !CE;
    endproperty
    a_mode_off: assert property (p_mode_off) else $error("detection while disabled");
endmodule // torque_channel
`default_nettype wire

//--- hdl/fault_restart_overtorque_supervisor.sv
// Fault restart and two-channel overtorque supervisor top
`timescale 1ns/10ps
`default_nettype none
// What this block does
// - An eligible trip while running starts an automatic restart, at most restart_limit (0 to 10) times.
// - Only the thirteen listed trips are eligible; any other trip latches the fault at once.
// - The restart count clears after ten minutes of healthy running after a restart, and at power-up.
// - A multi-function output set to code 1E is on while a restart is in progress.
// - restart_contact_select 1 drives the fault contact during a restart, 0 keeps it off.
// - Restart and overtorque settings are only taken while the drive is stopped.
// - Two overtorque channels each have a mode 0 to 4, a level 0 to 300 percent and a time 0.0 to 10.0 s.
// - Modes are off, agree-only alarm, any-time alarm, agree-only fault and any-time fault.
// - Overtorque is declared only when sensed load stays above the level longer than the time.
// - The sensed value is torque percent in vector modes and current percent in V/f modes, chosen upstream.
// - Output codes B, 17, 18 and 19 show channel 1 or 2 overtorque as normally open or closed.
// - A detection releases once the load drops about 5 percent below the level, or once mode and speed agreement no longer arm its channel.
module fault_restart_overtorque_supervisor
#(
    parameter int TICK_COUNT = supervisor_pkg::TICK_CYCLES,
    parameter int HEALTHY_COUNT = supervisor_pkg::HEALTHY_TICKS,
    parameter int RESTART_CYCLES = 16
)
(
    input wire logic CLOCK,
    input wire logic RESETN,
    input wire logic CE,
    input wire logic RUNNING,
    input wire logic SPEED_AGREE,
    input wire logic [supervisor_pkg::FAULT_BITS-1:0] ELIGIBLE_TRIPS,
    input wire logic OTHER_TRIP,
    input wire logic FAULT_RESET,
    input wire logic [8:0] SENSED_LOAD,
    input wire logic CONFIG_WRITE,
    input wire logic [3:0] RESTART_LIMIT_IN,
    input wire logic RESTART_CONTACT_SELECT_IN,
    input wire logic [2:0] TORQUE_CHAN1_MODE_IN,
    input wire logic [8:0] TORQUE_CHAN1_LEVEL_IN,
    input wire logic [6:0] TORQUE_CHAN1_TIME_IN,
    input wire logic [2:0] TORQUE_CHAN2_MODE_IN,
    input wire logic [8:0] TORQUE_CHAN2_LEVEL_IN,
    input wire logic [6:0] TORQUE_CHAN2_TIME_IN,
    input wire logic [4:0] MULTI_OUTPUT_1_FUNCTION,
    input wire logic [4:0] MULTI_OUTPUT_2_FUNCTION,
    input wire logic [4:0] MULTI_OUTPUT_3_FUNCTION,
    output logic CONFIG_REJECTED,
    output logic [3:0] RESTART_COUNT,
    output logic RESTART_REQUEST,
    output logic STOP_OUTPUT,
    output logic FAULT_CONTACT,
    output logic TORQUE_ALARM_1,
    output logic TORQUE_ALARM_2,
    output logic [2:0] MULTI_OUTPUT
);
    import supervisor_pkg::*;
    if (TICK_COUNT < 1 || HEALTHY_COUNT < 1 || RESTART_CYCLES < 1)
    begin : g_count_check
        $error("bad count parameter");
    end
    // ==========================================
    // Settings, taken only while stopped
    logic [3:0] restart_limit;
    logic restart_contact_select;
    logic [2:0] torque_chan1_mode;
    logic [8:0] torque_chan1_level;
    logic [6:0] torque_chan1_time;
    logic [2:0] torque_chan2_mode;
    logic [8:0] torque_chan2_level;
    logic [6:0] torque_chan2_time;
    wire logic config_valid = (RESTART_LIMIT_IN <= RESTART_LIMIT_MAX) && (TORQUE_CHAN1_MODE_IN <= MODE_ANY_FAULT) &&
        (TORQUE_CHAN2_MODE_IN <= MODE_ANY_FAULT) && (TORQUE_CHAN1_LEVEL_IN <= LEVEL_MAX) &&
        (TORQUE_CHAN2_LEVEL_IN <= LEVEL_MAX) && (TORQUE_CHAN1_TIME_IN <= TIME_MAX) &&
        (TORQUE_CHAN2_TIME_IN <= TIME_MAX);
    wire logic config_take = CONFIG_WRITE && !RUNNING && config_valid;
    always_ff @(posedge CLOCK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            restart_limit <= RESTART_LIMIT_RESET;
            restart_contact_select <= RESTART_CONTACT_RESET;
            torque_chan1_mode <= MODE_RESET;
            torque_chan1_level <= LEVEL_RESET;
            torque_chan1_time <= TIME_RESET;
            torque_chan2_mode <= MODE_RESET;
            torque_chan2_level <= LEVEL_RESET;
            torque_chan2_time <= TIME_RESET;
            CONFIG_REJECTED <= 1'b0;
        end
        else if (CE)
        begin
            CONFIG_REJECTED <= CONFIG_WRITE && !config_take;
            if (config_take)
            begin
                restart_limit <= RESTART_LIMIT_IN;
                restart_contact_select <= RESTART_CONTACT_SELECT_IN;
                torque_chan1_mode <= TORQUE_CHAN1_MODE_IN;
                torque_chan1_level <= TORQUE_CHAN1_LEVEL_IN;
                torque_chan1_time <= TORQUE_CHAN1_TIME_IN;
                torque_chan2_mode <= TORQUE_CHAN2_MODE_IN;
                torque_chan2_level <= TORQUE_CHAN2_LEVEL_IN;
                torque_chan2_time <= TORQUE_CHAN2_TIME_IN;
            end
        end
    end
    // ==========================================
    // Tenth-second tick
    logic [31:0] tick_div;
    logic tick;
    always_ff @(posedge CLOCK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            tick_div <= '0;
            tick <= 1'b0;
        end
        else if (CE)
        begin
            tick <= tick_div == 32'(TICK_COUNT - 1);
            tick_div <= (tick_div == 32'(TICK_COUNT - 1)) ? '0 : tick_div + 32'h1;
        end
    end
    // ==========================================
    // Overtorque channels
    logic trip_a;
    logic trip_b;
    torque_channel #(.TIME_WIDTH(7)) u_chan1 (.CLOCK(CLOCK), .RESETN(RESETN), .CE(CE), .TICK(tick),
        .MODE(torque_chan1_mode), .LEVEL(torque_chan1_level), .QUAL_TIME(torque_chan1_time),
        .SENSED(SENSED_LOAD), .SPEED_AGREE(SPEED_AGREE), .DETECTED(TORQUE_ALARM_1), .FAULT_EVENT(trip_a));
    torque_channel #(.TIME_WIDTH(7)) u_chan2 (.CLOCK(CLOCK), .RESETN(RESETN), .CE(CE), .TICK(tick),
        .MODE(torque_chan2_mode), .LEVEL(torque_chan2_level), .QUAL_TIME(torque_chan2_time),
        .SENSED(SENSED_LOAD), .SPEED_AGREE(SPEED_AGREE), .DETECTED(TORQUE_ALARM_2), .FAULT_EVENT(trip_b));
    // ==========================================
    // Restart sequencer
    logic [FAULT_BITS-1:0] trips;
    always_comb
    begin
        trips = ELIGIBLE_TRIPS;
        trips[TRIP_A_BIT] = ELIGIBLE_TRIPS[TRIP_A_BIT] | trip_a;
        trips[TRIP_B_BIT] = ELIGIBLE_TRIPS[TRIP_B_BIT] | trip_b;
    end
    wire logic eligible = |trips;
    wire logic may_retry = RESTART_COUNT < restart_limit;
    restart_state_t state;
    restart_state_t next_state;
    logic [31:0] healthy_ticks;
    logic [15:0] restart_timer;
    logic healthy_armed;
    always_comb
    begin
        next_state = state;
        case (state)
            ST_IDLE:
            begin
                if (OTHER_TRIP)
                    next_state = ST_LATCHED;
                else if (eligible && RUNNING && may_retry)
                    next_state = ST_RESTART;
                else if (eligible)
                    next_state = ST_LATCHED;
            end
            ST_RESTART:
            begin
                if (OTHER_TRIP)
                    next_state = ST_LATCHED;
                else if (restart_timer == 16'(RESTART_CYCLES - 1))
                    next_state = ST_IDLE;
            end
            ST_LATCHED:
            begin
                if (FAULT_RESET && !RUNNING)
                    next_state = ST_IDLE;
            end
            default: next_state = ST_LATCHED;
        endcase
    end
    always_ff @(posedge CLOCK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            state <= ST_IDLE;
            RESTART_COUNT <= '0;
            restart_timer <= '0;
            healthy_ticks <= '0;
            healthy_armed <= 1'b0;
        end
        else if (CE)
        begin
            state <= next_state;
            restart_timer <= (state == ST_RESTART) ? restart_timer + 16'h1 : '0;
            if (state == ST_IDLE && next_state == ST_RESTART)
            begin
                RESTART_COUNT <= RESTART_COUNT + 4'h1;
                healthy_armed <= 1'b1;
                healthy_ticks <= '0;
            end
            else if (state != ST_IDLE || !RUNNING || eligible)
                healthy_ticks <= '0;
            else if (healthy_armed && tick)
            begin
                if (healthy_ticks == 32'(HEALTHY_COUNT - 1))
                begin
                    RESTART_COUNT <= '0;
                    healthy_armed <= 1'b0;
                    healthy_ticks <= '0;
                end
                else
                    healthy_ticks <= healthy_ticks + 32'h1;
            end
        end
    end
    // ==========================================
    // Outputs
    wire logic restarting = state == ST_RESTART;
    wire logic [4:0] functions [3] = '{MULTI_OUTPUT_1_FUNCTION, MULTI_OUTPUT_2_FUNCTION, MULTI_OUTPUT_3_FUNCTION};
    logic [2:0] next_multi;
    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++)
        begin : g_out
            assign next_multi[gi] = ((functions[gi] == FUNC_RESTARTING) && restarting) ||
                ((functions[gi] == FUNC_TORQUE1_NO) && TORQUE_ALARM_1) ||
                ((functions[gi] == FUNC_TORQUE1_NC) && !TORQUE_ALARM_1) ||
                ((functions[gi] == FUNC_TORQUE2_NO) && TORQUE_ALARM_2) ||
                ((functions[gi] == FUNC_TORQUE2_NC) && !TORQUE_ALARM_2);
        end
    endgenerate
    always_ff @(posedge CLOCK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            MULTI_OUTPUT <= '0;
            FAULT_CONTACT <= 1'b0;
            STOP_OUTPUT <= 1'b0;
            RESTART_REQUEST <= 1'b0;
        end
        else if (CE)
        begin
            MULTI_OUTPUT <= next_multi;
            FAULT_CONTACT <= (state == ST_LATCHED) || (restarting && restart_contact_select);
            STOP_OUTPUT <= state != ST_IDLE;
            RESTART_REQUEST <= restarting && (restart_timer == 16'(RESTART_CYCLES - 1));
        end
    end
    // ==========================================
    // Checks
    sequence s_retry_start;
        CE && state == ST_IDLE && eligible && !OTHER_TRIP && RUNNING && may_retry;
    endsequence
    property p_retry;
        @(posedge CLOCK) disable iff (!RESETN)
        s_retry_start |=> state == ST_RESTART && RESTART_COUNT == $past(RESTART_COUNT) + 4'h1;
    endproperty
    a_retry: assert property (p_retry) else $error("eligible trip did not restart");
    property p_other;
        @(posedge CLOCK) disable iff (!RESETN)
        (CE && state == ST_IDLE && OTHER_TRIP) |=> state == ST_LATCHED;
    endproperty
    a_other: assert property (p_other) else $error("other trip did not latch");
    property p_limit;
        @(posedge CLOCK) disable iff (!RESETN)
        (CE && state == ST_IDLE && eligible && !may_retry) |=> state == ST_LATCHED;
    endproperty
    a_limit: assert property (p_limit) else $error("restart beyond limit");
    property p_count_bound;
        @(posedge CLOCK) disable iff (!RESETN)
        (RESTART_COUNT != $past(RESTART_COUNT) && RESTART_COUNT != 4'h0) |-> RESTART_COUNT <= restart_limit;
    endproperty
    a_count_bound: assert property (p_count_bound) else $error("count above limit");
    property p_reject;
        @(posedge CLOCK) disable iff (!RESETN)
        (CE && CONFIG_WRITE && RUNNING) |=> CONFIG_REJECTED && $stable(restart_limit) && $stable(torque_chan1_mode);
    endproperty
    a_reject: assert property (p_reject) else $error("setting taken while running");
    property p_indicate;
        @(posedge CLOCK) disable iff (!RESETN)
        (CE && restarting && MULTI_OUTPUT_1_FUNCTION == FUNC_RESTARTING) |=> MULTI_OUTPUT[0] || !CE;
    endproperty
    a_indicate: assert property (p_indicate) else $error("restart indication missing");
    property p_contact;
        @(posedge CLOCK) disable iff (!RESETN)
        (CE && restarting) |=> FAULT_CONTACT == $past(restart_contact_select) || !CE;
    endproperty
    a_contact: assert property (p_contact) else $error("fault contact wrong during restart");
    property p_healthy_clear;
        @(posedge CLOCK) disable iff (!RESETN)
        (CE && tick && healthy_armed && state == ST_IDLE && RUNNING && !eligible &&
            healthy_ticks == 32'(HEALTHY_COUNT - 1)) |=> RESTART_COUNT == 4'h0;
    endproperty
    a_healthy_clear: assert property (p_healthy_clear) else $error("count not cleared after healthy run");
endmodule // fault_restart_overtorque_supervisor
`default_nettype wire

//--- dv/drive_stage_model.sv
// Behavioural model of the drive power stage and current sensing
`timescale 1ns/10ps
`default_nettype none
module drive_stage_model
(
    input wire logic clock,
    input wire logic resetn,
    input wire logic run_cmd,
    input wire logic agree_cmd,
    input wire logic [8:0] load_cmd,
    input wire logic stop_output,
    output logic running,
    output logic speed_agree,
    output logic [8:0] sensed_load
);
    // ========================================
    // Run status and sensed load
    // No output current while the supervisor holds output off
    wire logic [8:0] next_sensed_load = (run_cmd && !stop_output) ? load_cmd : 9'h000;

    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            running <= 1'b0;
            speed_agree <= 1'b0;
            sensed_load <= 9'h000;
        end
        else
        begin
            running <= run_cmd;
            speed_agree <= run_cmd & agree_cmd;
            sensed_load <= next_sensed_load;
        end
    end
endmodule // drive_stage_model
`default_nettype wire

//--- dv/testbench.sv
// Self-checking bench for the fault restart and overtorque supervisor
`timescale 1ns/10ps
`default_nettype none
`define CHECK(got, exp) begin n_compared++; if ((got) !== (exp)) begin failures++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp); end end
`define WAIT_FOR(c, n) begin #1; for (k = 0; k < (n) && ((c) !== 1'b1); k++) begin @(posedge CLOCK); #1; end \
    if ((c) !== 1'b1) begin failures++; $display("MISMATCH t=%0t wait expired got=%h exp=%h", $time, 1'b0, 1'b1); \
    tally_and_finish(); end end
module testbench;
    import supervisor_pkg::*;
    logic CLOCK, RESETN, CE, RUNNING, SPEED_AGREE, OTHER_TRIP, FAULT_RESET, CONFIG_WRITE;
    logic [FAULT_BITS-1:0] ELIGIBLE_TRIPS;
    logic [8:0] SENSED_LOAD, load_cmd;
    logic run_cmd, agree_cmd, sel_in;
    logic [3:0] lim_in;
    logic [2:0] m1_in, m2_in;
    logic [8:0] l1_in, l2_in;
    logic [6:0] t1_in, t2_in;
    logic [4:0] f1, f2, f3;
    logic CONFIG_REJECTED, RESTART_REQUEST, STOP_OUTPUT, FAULT_CONTACT, TORQUE_ALARM_1, TORQUE_ALARM_2;
    logic [3:0] RESTART_COUNT;
    logic [2:0] MULTI_OUTPUT;
    int failures, n_compared, k;

    // ========================================
    // Design and drive model
    fault_restart_overtorque_supervisor #(.TICK_COUNT(10), .HEALTHY_COUNT(5), .RESTART_CYCLES(16))
    i_fault_restart_overtorque_supervisor (.CLOCK(CLOCK), .RESETN(RESETN), .CE(CE), .RUNNING(RUNNING),
        .SPEED_AGREE(SPEED_AGREE), .ELIGIBLE_TRIPS(ELIGIBLE_TRIPS), .OTHER_TRIP(OTHER_TRIP),
        .FAULT_RESET(FAULT_RESET), .SENSED_LOAD(SENSED_LOAD), .CONFIG_WRITE(CONFIG_WRITE),
        .RESTART_LIMIT_IN(lim_in), .RESTART_CONTACT_SELECT_IN(sel_in), .TORQUE_CHAN1_MODE_IN(m1_in),
        .TORQUE_CHAN1_LEVEL_IN(l1_in), .TORQUE_CHAN1_TIME_IN(t1_in), .TORQUE_CHAN2_MODE_IN(m2_in),
        .TORQUE_CHAN2_LEVEL_IN(l2_in), .TORQUE_CHAN2_TIME_IN(t2_in), .MULTI_OUTPUT_1_FUNCTION(f1),
        .MULTI_OUTPUT_2_FUNCTION(f2), .MULTI_OUTPUT_3_FUNCTION(f3), .CONFIG_REJECTED(CONFIG_REJECTED),
        .RESTART_COUNT(RESTART_COUNT), .RESTART_REQUEST(RESTART_REQUEST), .STOP_OUTPUT(STOP_OUTPUT),
        .FAULT_CONTACT(FAULT_CONTACT), .TORQUE_ALARM_1(TORQUE_ALARM_1), .TORQUE_ALARM_2(TORQUE_ALARM_2),
        .MULTI_OUTPUT(MULTI_OUTPUT));

    drive_stage_model i_drive_stage_model (.clock(CLOCK), .resetn(RESETN), .run_cmd(run_cmd),
        .agree_cmd(agree_cmd), .load_cmd(load_cmd), .stop_output(STOP_OUTPUT), .running(RUNNING),
        .speed_agree(SPEED_AGREE), .sensed_load(SENSED_LOAD));

    initial
    begin
        CLOCK = 1'b0;
        forever #5 CLOCK = ~CLOCK;
    end

    // ========================================
    // Shared tasks
    task automatic tally_and_finish();
        $display("Compared %0d values, %0d mismatches", n_compared, failures);
        if (failures == 0 && n_compared > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task automatic cfg(input logic [3:0] lim, input logic sel, input logic [2:0] m1, input logic [8:0] l1,
        input logic [6:0] t1, input logic [2:0] m2, input logic [8:0] l2, input logic [6:0] t2, input int rej);
        int seen;
        seen = 0;
        @(posedge CLOCK);
        lim_in <= lim; sel_in <= sel; m1_in <= m1; l1_in <= l1; t1_in <= t1;
        m2_in <= m2; l2_in <= l2; t2_in <= t2;
        CONFIG_WRITE <= 1'b1;
        @(posedge CLOCK);
        CONFIG_WRITE <= 1'b0;
        repeat (3)
        begin
            #1;
            if (CONFIG_REJECTED === 1'b1) seen++;
            @(posedge CLOCK);
        end
        `CHECK(seen, rej)
    endtask

    task automatic run(input logic on);
        @(posedge CLOCK);
        run_cmd <= on;
        repeat (3) @(posedge CLOCK);
    endtask

    task automatic clear_fault();
        run(1'b0);
        FAULT_RESET <= 1'b1;
        repeat (2) @(posedge CLOCK);
        FAULT_RESET <= 1'b0;
        repeat (3) @(posedge CLOCK);
        #1;
        `CHECK(STOP_OUTPUT, 1'b0)
    endtask

    task automatic trip(input logic [FAULT_BITS-1:0] bits, input logic other);
        @(posedge CLOCK);
        ELIGIBLE_TRIPS <= bits;
        OTHER_TRIP <= other;
        @(posedge CLOCK);
        ELIGIBLE_TRIPS <= '0;
        OTHER_TRIP <= 1'b0;
    endtask

    task automatic restart_one(input int b, input logic [3:0] cnt, input logic contact);
        logic [FAULT_BITS-1:0] v;
        v = '0;
        v[b] = 1'b1;
        trip(v, 1'b0);
        `WAIT_FOR(STOP_OUTPUT, 6)
        `CHECK(MULTI_OUTPUT[0], 1'b1)
        `CHECK(FAULT_CONTACT, contact)
        `CHECK(RESTART_COUNT, cnt)
        `WAIT_FOR(RESTART_REQUEST, 24)
        repeat (2) @(posedge CLOCK);
        #1;
        `CHECK(MULTI_OUTPUT[0], 1'b0)
        `CHECK(STOP_OUTPUT, 1'b0)
    endtask

    task automatic expect_latch(input logic [FAULT_BITS-1:0] bits, input logic other, input logic [3:0] cnt);
        int seen;
        seen = 0;
        trip(bits, other);
        `WAIT_FOR(STOP_OUTPUT, 6)
        repeat (24)
        begin
            @(posedge CLOCK);
            #1;
            if (RESTART_REQUEST === 1'b1) seen++;
        end
        `CHECK(seen, 0)
        `CHECK(STOP_OUTPUT, 1'b1)
        `CHECK(FAULT_CONTACT, 1'b1)
        `CHECK(RESTART_COUNT, cnt)
        `CHECK(MULTI_OUTPUT[0], 1'b0)
        clear_fault();
    endtask

    // ========================================
    // Main sequence
    initial
    begin
        RESETN = 1'b0; CE = 1'b1; OTHER_TRIP = 1'b0; FAULT_RESET = 1'b0; CONFIG_WRITE = 1'b0;
        ELIGIBLE_TRIPS = '0; load_cmd = 9'h000; run_cmd = 1'b0; agree_cmd = 1'b0;
        lim_in = 4'h0; sel_in = 1'b0; m1_in = 3'h0; m2_in = 3'h0; l1_in = 9'h096; l2_in = 9'h096;
        t1_in = 7'h01; t2_in = 7'h01; f1 = 5'h1E; f2 = 5'h0B; f3 = 5'h17;
        failures = 0; n_compared = 0;
        repeat (16) @(posedge CLOCK);
        RESETN <= 1'b1;
        repeat (3) @(posedge CLOCK);
        #1;
        `CHECK(RESTART_COUNT, 4'h0)
        `CHECK(MULTI_OUTPUT, 3'h4)
        `CHECK(FAULT_CONTACT, 1'b0)
        // Out of range values, then a valid write while running
        cfg(4'hB, 1'b0, 3'h0, 9'h096, 7'h01, 3'h0, 9'h096, 7'h01, 1);
        cfg(4'h2, 1'b0, 3'h5, 9'h096, 7'h01, 3'h0, 9'h096, 7'h01, 1);
        cfg(4'h2, 1'b0, 3'h0, 9'h12D, 7'h01, 3'h0, 9'h096, 7'h01, 1);
        cfg(4'h2, 1'b0, 3'h0, 9'h096, 7'h01, 3'h0, 9'h096, 7'h65, 1);
        run(1'b1);
        cfg(4'h5, 1'b0, 3'h0, 9'h096, 7'h01, 3'h0, 9'h096, 7'h01, 1);
        // Limit still zero: eligible trip latches at once
        expect_latch(13'h0001, 1'b0, 4'h0);
        // Full limit of ten restarts, then the eleventh latches
        cfg(4'hA, 1'b0, 3'h0, 9'h096, 7'h01, 3'h0, 9'h096, 7'h01, 0);
        run(1'b1);
        for (int b = 0; b < 10; b++) restart_one(b, 4'(b + 1), 1'b0);
        expect_latch(13'h0400, 1'b0, 4'hA);
        `CHECK(RESTART_COUNT, 4'hA)
        run(1'b1);
        `WAIT_FOR(RESTART_COUNT === 4'h0, 200)
        // Contact driven during restart; other trip never retries
        run(1'b0);
        cfg(4'h2, 1'b1, 3'h0, 9'h096, 7'h01, 3'h0, 9'h096, 7'h01, 0);
        run(1'b1);
        expect_latch(13'h0000, 1'b1, 4'h0);
        run(1'b1);
        restart_one(11, 4'h1, 1'b1);
        restart_one(12, 4'h2, 1'b1);
        // Channel 1 any-time alarm, channel 2 agree-only without agreement
        run(1'b0);
        cfg(4'h0, 1'b0, 3'h2, 9'h064, 7'h03, 3'h1, 9'h064, 7'h03, 0);
        run(1'b1);
        load_cmd <= 9'h078;
        repeat (25) @(posedge CLOCK);
        load_cmd <= 9'h032;
        repeat (5) @(posedge CLOCK);
        #1;
        `CHECK(TORQUE_ALARM_1, 1'b0)
        @(posedge CLOCK);
        load_cmd <= 9'h078;
        repeat (25) @(posedge CLOCK);
        #1;
        `CHECK(TORQUE_ALARM_1, 1'b0)
        `WAIT_FOR(TORQUE_ALARM_1, 60)
        repeat (2) @(posedge CLOCK);
        #1;
        `CHECK(MULTI_OUTPUT, 3'h2)
        `CHECK(TORQUE_ALARM_2, 1'b0)
        `CHECK(STOP_OUTPUT, 1'b0)
        @(posedge CLOCK);
        load_cmd <= 9'h061;
        repeat (30) @(posedge CLOCK);
        #1;
        `CHECK(TORQUE_ALARM_1, 1'b1)
        @(posedge CLOCK);
        load_cmd <= 9'h05E;
        `WAIT_FOR(TORQUE_ALARM_1 === 1'b0, 30)
        repeat (2) @(posedge CLOCK);
        #1;
        `CHECK(MULTI_OUTPUT, 3'h4)
        // Channel 2 any-time fault stops output; channel 1 agree fault above load
        run(1'b0);
        f2 <= 5'h18;
        f3 <= 5'h19;
        cfg(4'h0, 1'b0, 3'h3, 9'h0C8, 7'h00, 3'h4, 9'h064, 7'h00, 0);
        agree_cmd <= 1'b1;
        load_cmd <= 9'h078;
        run(1'b1);
        `WAIT_FOR(TORQUE_ALARM_2, 40)
        @(posedge CLOCK);
        #1;
        `CHECK(MULTI_OUTPUT[2:1], 2'h1)
        `CHECK(TORQUE_ALARM_1, 1'b0)
        `WAIT_FOR(STOP_OUTPUT, 10)
        `CHECK(RESTART_COUNT, 4'h0)
        clear_fault();
        tally_and_finish();
    end
endmodule // testbench
`default_nettype wire
